// file: flash_rww_pkg.sv
// Constants, encodings and carrier types of the flash self-program control.
package flash_rww_pkg;

    // Word address width of the program flash.
    localparam int ADDR_W = 16;
    // Size of the halting region in words, at the top of flash.
    localparam logic [15:0] HALT_WORDS = 16'h1000;
    // Boot region sizes in words for boot_size_fuses 3..0.
    localparam logic [15:0] BOOT_SZ_3 = 16'h0200;
    localparam logic [15:0] BOOT_SZ_2 = 16'h0400;
    localparam logic [15:0] BOOT_SZ_1 = 16'h0800;
    localparam logic [15:0] BOOT_SZ_0 = 16'h1000;
    // Time in ns taken by a page erase or page write, and the same in clock cycles.
    localparam int PAGE_OP_NS = 40_000;
    localparam int CLK_NS = 10;
    localparam int PAGE_OP_CYC = PAGE_OP_NS / CLK_NS;
    // Lock pair value with both bits unprogrammed.
    localparam logic [1:0] LOCK_OPEN = 2'h3;

    // Avalon register word addresses.
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_ADDR = 2'h1;
    localparam logic [1:0] REG_LOCK = 2'h2;
    localparam logic [1:0] REG_STAT = 2'h3;
    // Control register fields.
    localparam int CTRL_GO = 0;
    localparam int CTRL_ERASE = 1;
    localparam int CTRL_CLR_BUSY = 2;
    localparam int CTRL_FROM_BOOT = 3;
    // Lock register fields.
    localparam int LOCK_APP_LO = 0;
    localparam int LOCK_BOOT_LO = 2;
    // Status register fields.
    localparam int STAT_BUSY = 0;
    localparam int STAT_STALL = 1;
    localparam int STAT_RUN = 2;
    localparam int STAT_IGN = 3;

    // Program-store request seen from the core.
    typedef struct packed {
        logic go;
        logic erase;
        logic from_boot;
        logic [ADDR_W-1:0] target;
    } store_req_t;

    // Flash array command towards the page programming engine.
    typedef struct packed {
        logic start;
        logic erase;
        logic [ADDR_W-1:0] target;
    } flash_cmd_t;

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY} op_state_t;

endpackage

// file: lock_store.sv
// Holds the boot lock pairs: bits only program, chip erase clears.
`timescale 1ns/1ps
`default_nettype none
module lock_store (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Software write and chip erase.
    input wire logic wr_en,
    input wire logic [3:0] wr_data,
    input wire logic chip_erase,
    // Current lock pairs.
    output logic [3:0] locks
);
    import flash_rww_pkg::*;
    logic [3:0] locks_q;
    logic [3:0] locks_d;

    // Writing zero programs a bit; only chip erase or reset returns it to one.
    always_comb begin
        locks_d = locks_q;
        if (chip_erase) begin
            locks_d = {LOCK_OPEN, LOCK_OPEN};
        end else if (wr_en) begin
            locks_d = locks_q & wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            locks_q <= {LOCK_OPEN, LOCK_OPEN};
        end else begin
            locks_q <= locks_d;
        end
    end

    assign locks = locks_q;
endmodule
`default_nettype wire

// file: flash_self_program_rww_control.sv
// Self-program sequencer: region checks, locks, stall and busy flag.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_rww_control #(
    parameter int PAGE_CYC = flash_rww_pkg::PAGE_OP_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Fuses and chip erase.
    input wire logic [1:0] boot_size_fuses,
    input wire logic chip_erase,
    // Avalon-MM slave.
    input wire logic [1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Core fetch side.
    input wire logic [flash_rww_pkg::ADDR_W-1:0] fetch_addr,
    output logic core_stall,
    output logic fetch_in_boot,
    // Flash array command and done.
    output flash_rww_pkg::flash_cmd_t flash_cmd,
    input wire logic flash_done
);
    import flash_rww_pkg::*;

    // Refuse a page time that the down-counter cannot serve.
    if (PAGE_CYC < 1) begin : g_bad_page
        $error("PAGE_CYC must be at least one");
    end

    // Reset synchroniser.
    logic rs1_q;
    logic rs2_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    wire logic rst_n = rs2_q;

    // Boot region start address from the fuses.
    function automatic logic [15:0] boot_start(input logic [1:0] f);
        logic [15:0] sz;
        case (f)
            2'h3: sz = BOOT_SZ_3;
            2'h2: sz = BOOT_SZ_2;
            2'h1: sz = BOOT_SZ_1;
            default: sz = BOOT_SZ_0;
        endcase
        boot_start = 16'h0000 - sz;
    endfunction

    // Halting region is a fixed top slice; boot never exceeds it.
    function automatic logic in_halt(input logic [15:0] a);
        in_halt = a >= (16'h0000 - HALT_WORDS);
    endfunction

    logic [15:0] boot_base;
    // Boot sizes never exceed the halting size, so boot sits within it.
    assign boot_base = boot_start(boot_size_fuses);

    // Lock pairs.
    logic [3:0] locks;
    logic lock_wr;
    lock_store u_locks (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(lock_wr),
        .wr_data(writedata[3:0]),
        .chip_erase(chip_erase),
        .locks(locks)
    );
    logic [1:0] app_lock;
    logic [1:0] boot_lock;
    assign app_lock = locks[LOCK_APP_LO +: 2];
    assign boot_lock = locks[LOCK_BOOT_LO +: 2];

    // Software-visible registers and sequencer state.
    op_state_t st_q, st_d;
    logic [15:0] addr_q, addr_d;
    logic [31:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic stall_q, stall_d;
    logic ign_q, ign_d;
    logic erase_q, erase_d;
    logic [31:0] rdata_q, rdata_d;
    logic wait_q, wait_d;
    logic boot_q, boot_d;
    flash_cmd_t cmd_q, cmd_d;
    store_req_t req;
    logic tgt_boot;
    logic write_ok;

    // A store is decoded from a control write.
    always_comb begin
        req.go = write && !wait_q && address == REG_CTRL
            && writedata[CTRL_GO];
        req.erase = writedata[CTRL_ERASE];
        req.from_boot = writedata[CTRL_FROM_BOOT];
        req.target = addr_q;
    end

    // Target section and its lock decide whether the store proceeds.
    assign tgt_boot = req.target >= boot_base;
    always_comb begin
        if (tgt_boot) begin
            write_ok = boot_lock[0];
        end else begin
            write_ok = app_lock[0];
        end
    end

    assign lock_wr = write && !wait_q && address == REG_LOCK;

    // Sequencer, busy flag and bus answer.
    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        stall_d = stall_q;
        ign_d = ign_q;
        erase_d = erase_q;
        rdata_d = rdata_q;
        wait_d = 1'b1;
        boot_d = fetch_addr >= boot_base;
        cmd_d = '0;
        cmd_d.target = addr_q;
        cmd_d.erase = erase_q;
        if (wait_q) begin
            wait_d = !(read || write);
        end else begin
            wait_d = 1'b1;
        end
        if ((read || write) && wait_q) begin
            wait_d = 1'b0;
        end
        if (write && !wait_q && address == REG_ADDR) begin
            addr_d = writedata[15:0];
        end
        if (write && !wait_q && address == REG_CTRL
            && writedata[CTRL_CLR_BUSY] && st_q == ST_IDLE) begin
            busy_d = 1'b0;
        end
        // Read data are latched when the request is first seen, so they
        // stand at the edge where the master sees waitrequest low.
        if (read && wait_q) begin
            rdata_d = '0;
            case (address)
                REG_CTRL: rdata_d = '0;
                REG_ADDR: rdata_d[15:0] = addr_q;
                REG_LOCK: rdata_d[3:0] = locks;
                REG_STAT: begin
                    rdata_d[STAT_BUSY] = busy_q;
                    rdata_d[STAT_STALL] = stall_q;
                    rdata_d[STAT_RUN] = st_q == ST_BUSY;
                    rdata_d[STAT_IGN] = ign_q;
                end
                default: rdata_d = '0;
            endcase
        end
        case (st_q)
            ST_IDLE: begin
                if (req.go) begin
                    if (!req.from_boot || !write_ok) begin
                        ign_d = 1'b1;
                    end else begin
                        ign_d = 1'b0;
                        st_d = ST_BUSY;
                        erase_d = req.erase;
                        cmd_d.start = 1'b1;
                        cmd_d.erase = req.erase;
                        cmd_d.target = req.target;
                        cnt_d = 32'(PAGE_CYC);
                        if (in_halt(req.target)) begin
                            stall_d = 1'b1;
                        end else begin
                            busy_d = 1'b1;
                        end
                    end
                end
            end
            ST_BUSY: begin
                // Concurrent-read work leaves stall low.
                if (cnt_q != 32'h0000_0000) begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end
                if (flash_done || cnt_q == 32'h0000_0001) begin
                    st_d = ST_IDLE;
                    stall_d = 1'b0;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            addr_q <= 16'h0000;
            cnt_q <= 32'h0000_0000;
            busy_q <= 1'b0;
            stall_q <= 1'b0;
            ign_q <= 1'b0;
            erase_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            wait_q <= 1'b1;
            boot_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            stall_q <= stall_d;
            ign_q <= ign_d;
            erase_q <= erase_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
            boot_q <= boot_d;
            cmd_q <= cmd_d;
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign core_stall = stall_q;
    assign fetch_in_boot = boot_q;
    assign flash_cmd = cmd_q;
endmodule
`default_nettype wire

// file: flash_array_model.sv
// Flash array model that answers page commands after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
    import flash_rww_pkg::*;
(
    // Clock.
    input wire logic mclk,
    // Command in, answer out.
    input wire flash_rww_pkg::flash_cmd_t flash_cmd,
    input wire logic [4:0] delay,
    output logic flash_done = 1'b0
);
    int cnt = 0;
    // Count down from each command, then pulse done once.
    always @(posedge mclk) begin
        flash_done <= (cnt == 1);
        if (flash_cmd.start) cnt <= int'(delay);
        else if (cnt != 0) cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// file: flash_rww_checker.sv
// Assertions on the ports of the self-program sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_rww_checker
    import flash_rww_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Inputs watched.
    input wire logic [1:0] boot_size_fuses,
    input wire logic [1:0] address,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [15:0] fetch_addr,
    // Outputs watched.
    input wire logic waitrequest,
    input wire logic core_stall,
    input wire logic fetch_in_boot,
    input wire flash_rww_pkg::flash_cmd_t flash_cmd
);
    localparam logic [15:0] HB = 16'h0000 - HALT_WORDS;
    logic [1:0] up_q;
    logic [15:0] tgt_q, op_q, cur;
    logic acc_boot;
    // Start of the split region for a fuse setting.
    function automatic logic [15:0] base_of(input logic [1:0] f);
        return 16'h0000 - (f == 2'h3 ? BOOT_SZ_3 : f == 2'h2 ? BOOT_SZ_2 :
            f == 2'h1 ? BOOT_SZ_1 : BOOT_SZ_0);
    endfunction
    // Track settling after reset, the stored target and the running one.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            up_q <= 2'h0;
            tgt_q <= 16'h0000;
            op_q <= 16'h0000;
        end else begin
            if (up_q != 2'h3) up_q <= up_q + 2'h1;
            if (write && !waitrequest && address == REG_ADDR) begin
                tgt_q <= writedata[15:0];
            end
            if (flash_cmd.start) op_q <= flash_cmd.target;
        end
    end
    // Accepted store from boot code, and the target now in force.
    assign acc_boot = write && !waitrequest && address == REG_CTRL &&
        writedata[CTRL_GO] && writedata[CTRL_FROM_BOOT];
    assign cur = flash_cmd.start ? flash_cmd.target : op_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn || up_q != 2'h3);
    a_start_pulse: assert property (flash_cmd.start |=> !flash_cmd.start)
        else $error("start longer than one cycle");
    a_app_ignored: assert property (
        write && !waitrequest && address == REG_CTRL &&
        writedata[CTRL_GO] && !writedata[CTRL_FROM_BOOT]
        |=> !flash_cmd.start)
        else $error("store from application started");
    a_start_cause: assert property (flash_cmd.start |-> $past(acc_boot))
        else $error("start without boot store");
    a_target_kept: assert property (
        flash_cmd.start |-> flash_cmd.target == tgt_q)
        else $error("target differs from address");
    a_rww_run: assert property (
        flash_cmd.start && flash_cmd.target < HB |=> !core_stall [*4])
        else $error("core stalled on concurrent page");
    a_halt_stall: assert property (
        flash_cmd.start && flash_cmd.target >= HB
        |=> ##1 core_stall [*2])
        else $error("core not stalled on halting page");
    a_stall_bound: assert property (
        $rose(core_stall) |-> ##[1:8] !core_stall)
        else $error("stall too long");
    a_stall_halt: assert property (core_stall |-> cur >= HB)
        else $error("stall for wrong region");
    a_boot_halt: assert property (
        fetch_in_boot |-> $past(fetch_addr) >= HB)
        else $error("boot outside halting region");
    a_boot_split: assert property (
        fetch_in_boot ==
        ($past(fetch_addr) >= base_of($past(boot_size_fuses))))
        else $error("boot split wrong");
    c_rww_op: cover property (flash_cmd.start && flash_cmd.target < HB);
    c_halt_op: cover property ($rose(core_stall));
    c_boot: cover property ($rose(fetch_in_boot));
endmodule
bind flash_self_program_rww_control flash_rww_checker chk (.mclk(mclk),
    .resetn(resetn), .boot_size_fuses(boot_size_fuses), .address(address),
    .write(write), .writedata(writedata), .fetch_addr(fetch_addr),
    .waitrequest(waitrequest), .core_stall(core_stall),
    .fetch_in_boot(fetch_in_boot), .flash_cmd(flash_cmd));
`default_nettype wire

// file: flash_self_program_rww_control_bench.sv
// Self-checking bench of the self-program sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_rww_control_bench;
    import flash_rww_pkg::*;
    logic mclk = 0, resetn = 0, chip_erase = 0, read = 0, write = 0;
    logic [1:0] boot_size_fuses = 2'h0, address = 2'h0;
    logic [31:0] writedata = 32'h0000_0000, readdata, q;
    logic waitrequest, core_stall, fetch_in_boot, flash_done;
    logic [15:0] fetch_addr = 16'h0000;
    logic [4:0] delay = 5'h03;
    flash_cmd_t flash_cmd;
    int n_mismatch = 0, n_tests = 0;
    // Clock at 100 MHz.
    always #5 mclk = ~mclk;
    flash_self_program_rww_control #(.PAGE_CYC(5)) dut (.mclk(mclk),
        .resetn(resetn), .boot_size_fuses(boot_size_fuses),
        .chip_erase(chip_erase), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .fetch_addr(fetch_addr),
        .core_stall(core_stall), .fetch_in_boot(fetch_in_boot),
        .flash_cmd(flash_cmd), .flash_done(flash_done));
    flash_array_model fam (.mclk(mclk), .flash_cmd(flash_cmd),
        .delay(delay), .flash_done(flash_done));
    // Compare and count.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One bus transfer; read data lands in q.
    task bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        int i;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (waitrequest !== 1'b0 && i < 50);
        // Read data stand at the same edge as waitrequest low.
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (i >= 50) begin
            check(32'h0, 32'h1);
            stop_test;
        end
        @(posedge mclk);
    endtask
    function automatic logic [15:0] base_of(input logic [1:0] f);
        return 16'h0000 - (f == 2'h3 ? BOOT_SZ_3 : f == 2'h2 ? BOOT_SZ_2 :
            f == 2'h1 ? BOOT_SZ_1 : BOOT_SZ_0);
    endfunction
    // Issue a store and check start, stall and busy flag.
    task store(input logic [15:0] t, input logic fb, input logic ok);
        logic seen, stl;
        seen = 0;
        stl = 0;
        bus(1'b1, REG_ADDR, {16'h0000, t});
        bus(1'b1, REG_CTRL, {28'h000_0000, fb, 1'b0, t[0], 1'b1});
        // Start stands for one cycle just as the control write returns.
        for (int i = 0; i < 20; i++) begin
            if (flash_cmd.start === 1'b1) seen = 1;
            if (flash_cmd.start === 1'b1) check(flash_cmd.target, t);
            if (flash_cmd.start === 1'b1) check(flash_cmd.erase, t[0]);
            if (core_stall === 1'b1) stl = 1;
            @(posedge mclk);
        end
        check(seen, ok);
        check(stl, ok && t >= 16'hF000);
        bus(1'b0, REG_STAT, 32'h0000_0000);
        check(q[STAT_BUSY], ok && t < 16'hF000);
        check(q[STAT_IGN], !ok);
        check(q[STAT_STALL], 1'b0);
        check(q[STAT_RUN], 1'b0);
        bus(1'b1, REG_CTRL, 32'h0000_0004);
        bus(1'b0, REG_STAT, 32'h0000_0000);
        check(q[STAT_BUSY], 1'b0);
    endtask
    // Main sequence.
    initial begin
        logic [15:0] t;
        logic fb;
        void'($urandom(32'h2c1c_3094));
        repeat (4) @(posedge mclk);
        check(waitrequest, 1'b1);
        check(core_stall, 1'b0);
        resetn <= 1'b1;
        repeat (6) @(posedge mclk);
        bus(1'b0, REG_LOCK, 32'h0000_0000);
        check(q[3:0], 4'hF);
        for (int f = 0; f < 4; f++) begin
            boot_size_fuses <= f[1:0];
            fetch_addr <= base_of(f[1:0]);
            repeat (2) @(posedge mclk);
            check(fetch_in_boot, 1'b1);
            fetch_addr <= base_of(f[1:0]) - 16'h0001;
            repeat (2) @(posedge mclk);
            check(fetch_in_boot, 1'b0);
        end
        boot_size_fuses <= 2'h0;
        // Keep the core fetching boot code while pages are programmed.
        fetch_addr <= base_of(2'h0);
        store(16'h0100, 1'b0, 1'b0);
        store(16'h0100, 1'b1, 1'b1);
        delay <= 5'h14;
        store(16'hF800, 1'b1, 1'b1);
        repeat (6) begin
            t = 16'($urandom);
            fb = 1'($urandom);
            delay <= 5'(3 + $urandom % 20);
            store(t, fb, fb);
        end
        bus(1'b1, REG_LOCK, 32'h0000_000E);
        store(16'h0100, 1'b1, 1'b0);
        store(16'hF800, 1'b1, 1'b1);
        bus(1'b1, REG_LOCK, 32'h0000_000F);
        bus(1'b0, REG_LOCK, 32'h0000_0000);
        check(q[3:0], 4'hE);
        chip_erase <= 1'b1;
        @(posedge mclk);
        chip_erase <= 1'b0;
        bus(1'b0, REG_LOCK, 32'h0000_0000);
        check(q[3:0], 4'hF);
        stop_test;
    end
    // Cut a hang short.
    initial begin
        repeat (20000) @(posedge mclk);
        check(32'h0, 32'h1);
        stop_test;
    end
endmodule
`default_nettype wire
